// ---- logic/pau_map.svh ----
// register offsets, field positions, reset values and topology codes of the primitive assembly unit
`ifndef PAU_MAP_SVH
`define PAU_MAP_SVH

`define PAU_ADDR_W              8
`define PAU_REG_CFG             8'h00
`define PAU_REG_STATUS          8'h04
`define PAU_REG_OBJ_COUNT       8'h08

`define PAU_CFG_LINE_PV_LSB     0
`define PAU_CFG_TRI_PV_LSB      2
`define PAU_CFG_FAN_PV_LSB      4
`define PAU_CFG_RESET           6'h00

`define PAU_ST_BAD_TOPO         0
`define PAU_ST_OBJ_PENDING      1
`define PAU_ST_MID_PRIM         2

`define PAU_TOPO_W              5
`define PAU_TOPO_POINT_LIST     5'h01
`define PAU_TOPO_POINT_LIST_BF  5'h02
`define PAU_TOPO_LINE_LIST      5'h03
`define PAU_TOPO_LINE_STRIP     5'h04
`define PAU_TOPO_LINE_STRIP_CT  5'h05
`define PAU_TOPO_LINE_STRIP_BF  5'h06
`define PAU_TOPO_LINE_STRIP_CBF 5'h07
`define PAU_TOPO_TRI_LIST       5'h08
`define PAU_TOPO_TRI_STRIP      5'h09
`define PAU_TOPO_TRI_STRIP_REV  5'h0A
`define PAU_TOPO_TRI_FAN        5'h0B
`define PAU_TOPO_TRI_FAN_NP     5'h0C
`define PAU_TOPO_POLYGON        5'h0D
`define PAU_TOPO_RECT_LIST      5'h0E

`define PAU_SHAPE_POINT         2'h0
`define PAU_SHAPE_LINE          2'h1
`define PAU_SHAPE_TRIANGLE      2'h2
`define PAU_SHAPE_RECTANGLE     2'h3

`define PAU_NV_POINT            2'h1
`define PAU_NV_LINE             2'h2
`define PAU_NV_TRIANGLE         2'h3
`define PAU_PV_FIRST            2'h0

`endif

// ---- logic/pau_pkg.sv ----
// types shared by the primitive assembly unit
`default_nettype none
`include "pau_map.svh"
package pau_pkg;
	typedef enum logic [`PAU_TOPO_W-1:0] {
		topo_point_list         = `PAU_TOPO_POINT_LIST,
		topo_point_list_bf      = `PAU_TOPO_POINT_LIST_BF,
		topo_line_list          = `PAU_TOPO_LINE_LIST,
		topo_line_strip         = `PAU_TOPO_LINE_STRIP,
		topo_line_strip_ct      = `PAU_TOPO_LINE_STRIP_CT,
		topo_line_strip_bf      = `PAU_TOPO_LINE_STRIP_BF,
		topo_line_strip_cbf     = `PAU_TOPO_LINE_STRIP_CBF,
		topo_tri_list           = `PAU_TOPO_TRI_LIST,
		topo_tri_strip          = `PAU_TOPO_TRI_STRIP,
		strip_reversed_topology = `PAU_TOPO_TRI_STRIP_REV,
		topo_tri_fan            = `PAU_TOPO_TRI_FAN,
		fan_without_pattern     = `PAU_TOPO_TRI_FAN_NP,
		polygon_topology        = `PAU_TOPO_POLYGON,
		rectangle_list_topology = `PAU_TOPO_RECT_LIST
	} pau_topo_e;

	typedef enum logic [1:0] {
		point_shape     = `PAU_SHAPE_POINT,
		line_shape      = `PAU_SHAPE_LINE,
		triangle_shape  = `PAU_SHAPE_TRIANGLE,
		rectangle_shape = `PAU_SHAPE_RECTANGLE
	} pau_shape_e;
endpackage : pau_pkg
`default_nettype wire

// ---- logic/pau_vtx_hist.sv ----
// vertex history: first vertex of the topology and the two most recent vertices
`timescale 1ns/1ns
`default_nettype none
module pau_vtx_hist #(
	parameter int REC_W = 58
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             reset,
	// vertex taken
	input  wire logic             take,
	input  wire logic             first,
	input  wire logic [REC_W-1:0] rec_in,
	// history
	output logic      [REC_W-1:0] anchor,
	output logic      [REC_W-1:0] prev1,
	output logic      [REC_W-1:0] prev2
);
	logic [REC_W-1:0] hist_q [0:1];
	logic [REC_W-1:0] anchor_q;

	if (REC_W < 4) begin : g_bad_width
		$error("pau_vtx_hist: record too narrow");
	end

	assign anchor = anchor_q;
	assign prev1  = hist_q[0];
	assign prev2  = hist_q[1];

	// every taken vertex shifts in; old history is still read in the taking cycle
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			hist_q[0] <= '0;
			hist_q[1] <= '0;
			anchor_q  <= '0;
		end else if (take) begin
			hist_q[0] <= rec_in;
			hist_q[1] <= hist_q[0];
			if (first) begin
				anchor_q <= rec_in;
			end
		end
	end
endmodule : pau_vtx_hist
`default_nettype wire

// ---- logic/pau_primitive_assembly.sv ----
// primitive assembly: vertex stream in, point/line/triangle/rectangle objects out
`timescale 1ns/1ns
`default_nettype none
`include "pau_map.svh"
module pau_primitive_assembly #(
	parameter int DATA_W  = 32,
	parameter int LAYER_W = 11,
	parameter int SEL_W   = 4,
	parameter int SIZE_W  = 11
) (
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   reset,
	// register port
	input  wire logic [`PAU_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire logic                   reg_write,
	input  wire logic                   reg_read,
	output logic      [31:0]            reg_rdata,
	// vertex stream from the clipper
	input  wire logic                   vtx_valid,
	output logic                        vtx_ready,
	input  wire logic [`PAU_TOPO_W-1:0] topology_kind,
	input  wire logic                   vtx_start,
	input  wire logic                   vtx_end,
	input  wire logic [DATA_W-1:0]      vtx_data,
	input  wire logic [LAYER_W-1:0]     layer_slot_index,
	input  wire logic [SEL_W-1:0]       transform_selector,
	input  wire logic [SIZE_W-1:0]      dot_extent,
	// object stream to the viewport transform
	output logic                        obj_valid,
	input  wire logic                   obj_ready,
	output logic      [1:0]             shape_class,
	output logic      [1:0]             shape_vertex_count,
	output logic      [DATA_W-1:0]      obj_v0,
	output logic      [DATA_W-1:0]      obj_v1,
	output logic      [DATA_W-1:0]      obj_v2,
	output logic                        winding_flip,
	output logic                        rear_face_flag,
	output logic      [1:0]             flat_shade_source,
	output logic                        area_pattern_on,
	output logic                        dash_pattern_resume,
	output logic      [LAYER_W-1:0]     obj_layer,
	output logic      [SEL_W-1:0]       obj_selector,
	output logic      [SIZE_W-1:0]      obj_dot_extent
);
	localparam int REC_W = DATA_W + LAYER_W + SEL_W + SIZE_W;

	if (DATA_W < 1 || LAYER_W < 1 || SEL_W < 1 || SIZE_W < 1 || LAYER_W > 32 || SEL_W > 32) begin : g_bad_param
		$error("pau_primitive_assembly: field widths out of range");
	end

	// record layout {data, layer, selector, size}
	function automatic logic [DATA_W-1:0] rec_data(input logic [REC_W-1:0] r);
		rec_data = r[REC_W-1 -: DATA_W];
	endfunction : rec_data

	function automatic logic [LAYER_W-1:0] rec_layer(input logic [REC_W-1:0] r);
		rec_layer = r[SEL_W+SIZE_W +: LAYER_W];
	endfunction : rec_layer

	function automatic logic [SEL_W-1:0] rec_sel(input logic [REC_W-1:0] r);
		rec_sel = r[SIZE_W +: SEL_W];
	endfunction : rec_sel

	function automatic logic [SIZE_W-1:0] rec_size(input logic [REC_W-1:0] r);
		rec_size = r[SIZE_W-1:0];
	endfunction : rec_size

	// state
	logic        in_ready_q;
	logic        obj_valid_q;
	logic [1:0]  pos_q;
	logic        flip_q;
	logic        resume_q;
	logic        bad_topo_q;
	logic        mid_prim_q;
	logic [5:0]  cfg_q;
	logic [15:0] obj_count_q;
	logic [31:0] rdata_q;

	logic [1:0]         shape_q;
	logic [1:0]         nv_q;
	logic [DATA_W-1:0]  v0_q;
	logic [DATA_W-1:0]  v1_q;
	logic [DATA_W-1:0]  v2_q;
	logic               flip_out_q;
	logic               rear_q;
	logic [1:0]         pv_q;
	logic               area_q;
	logic               dash_q;
	logic [LAYER_W-1:0] layer_q;
	logic [SEL_W-1:0]   sel_q;
	logic [SIZE_W-1:0]  size_q;

	// topology decode
	pau_pkg::pau_topo_e topo;
	assign topo = pau_pkg::pau_topo_e'(topology_kind);

	wire is_point   = topo == pau_pkg::topo_point_list || topo == pau_pkg::topo_point_list_bf;
	wire is_lline   = topo == pau_pkg::topo_line_list;
	wire is_lstrip  = topo == pau_pkg::topo_line_strip || topo == pau_pkg::topo_line_strip_ct
		|| topo == pau_pkg::topo_line_strip_bf || topo == pau_pkg::topo_line_strip_cbf;
	wire is_tlist   = topo == pau_pkg::topo_tri_list;
	wire is_rect    = topo == pau_pkg::rectangle_list_topology;
	wire is_tstrip  = topo == pau_pkg::topo_tri_strip || topo == pau_pkg::strip_reversed_topology;
	wire is_fan_np  = topo == pau_pkg::fan_without_pattern;
	wire is_poly    = topo == pau_pkg::polygon_topology; // clipped objects land here too
	wire is_fan     = topo == pau_pkg::topo_tri_fan || is_fan_np || is_poly;
	wire is_line    = is_lline | is_lstrip;
	wire is_tri     = is_tlist | is_tstrip | is_fan;
	wire is_list    = is_point | is_lline | is_tlist | is_rect;
	// unknown codes such as quads or loops are taken and dropped so the stream never hangs
	wire topo_ok    = is_point | is_line | is_tri | is_rect;

	wire bf_topo    = topo == pau_pkg::topo_point_list_bf || topo == pau_pkg::topo_line_strip_bf
		|| topo == pau_pkg::topo_line_strip_cbf;
	wire cont_topo  = topo == pau_pkg::topo_line_strip_ct || topo == pau_pkg::topo_line_strip_cbf;
	wire rev_topo   = topo == pau_pkg::strip_reversed_topology;

	// vertices per object
	wire [1:0] need_nv = is_point ? `PAU_NV_POINT : (is_line ? `PAU_NV_LINE : `PAU_NV_TRIANGLE);
	wire [1:0] last_pos = need_nv - 2'h1;

	// position in current object; strips saturate so every later vertex closes one object
	wire       take     = vtx_valid & in_ready_q;
	wire       first    = vtx_start | ~mid_prim_q;
	wire [1:0] pos_cur  = first ? 2'h0 : pos_q;
	wire       complete = pos_cur == last_pos;
	wire       emit     = take & topo_ok & complete;
	wire [1:0] pos_next = complete ? (is_list ? 2'h0 : pos_cur) : pos_cur + 2'h1;

	// history records
	wire [REC_W-1:0] cur_rec = {vtx_data, layer_slot_index, transform_selector, dot_extent};
	logic [REC_W-1:0] anchor_rec;
	logic [REC_W-1:0] prev1_rec;
	logic [REC_W-1:0] prev2_rec;

	pau_vtx_hist #(
		.REC_W (REC_W)
	) u_hist (
		.mclk   (mclk),
		.reset  (reset),
		.take   (take),
		.first  (first),
		.rec_in (cur_rec),
		.anchor (anchor_rec),
		.prev1  (prev1_rec),
		.prev2  (prev2_rec)
	);

	// leading vertex: own point, first of line, first of triple/strip triangle, v0 for fans
	wire [REC_W-1:0] lead_rec = is_point ? cur_rec : (is_line ? prev1_rec : (is_fan ? anchor_rec : prev2_rec));

	// object vertex order
	wire [DATA_W-1:0] v0_d = is_point ? rec_data(cur_rec) : (is_line ? rec_data(prev1_rec)
		: (is_fan ? rec_data(anchor_rec) : rec_data(prev2_rec)));
	wire [DATA_W-1:0] v1_d = is_point ? '0 : (is_line ? rec_data(cur_rec) : rec_data(prev1_rec));
	wire [DATA_W-1:0] v2_d = (is_point | is_line) ? '0 : rec_data(cur_rec);

	wire [1:0] shape_d = is_point ? `PAU_SHAPE_POINT : (is_line ? `PAU_SHAPE_LINE
		: (is_rect ? `PAU_SHAPE_RECTANGLE : `PAU_SHAPE_TRIANGLE));

	// flat shade source per class; polygons pinned to vertex 0
	wire [1:0] line_pv = cfg_q[`PAU_CFG_LINE_PV_LSB +: 2];
	wire [1:0] tri_pv  = cfg_q[`PAU_CFG_TRI_PV_LSB +: 2];
	wire [1:0] fan_pv  = cfg_q[`PAU_CFG_FAN_PV_LSB +: 2];
	wire [1:0] pv_d    = (is_point | is_poly) ? `PAU_PV_FIRST : (is_line ? line_pv : (is_fan ? fan_pv : tri_pv));

	// strip winding: the flag for this triangle, reloaded at every new strip
	wire flip_cur  = first ? rev_topo : flip_q;
	wire flip_d    = is_tstrip & flip_cur;
	wire rear_d    = bf_topo & (is_point | is_line);
	wire area_d    = is_tri & ~is_fan_np;
	wire resume_c  = first ? cont_topo : resume_q;
	wire dash_d    = is_lstrip & resume_c; // line lists always restart

	// register decode
	wire sel_cfg    = reg_addr == `PAU_REG_CFG;
	wire sel_status = reg_addr == `PAU_REG_STATUS;
	wire sel_count  = reg_addr == `PAU_REG_OBJ_COUNT;
	wire clr_bad    = reg_write & sel_status & reg_wdata[`PAU_ST_BAD_TOPO];

	logic [31:0] status_word;
	always_comb begin
		status_word                      = '0;
		status_word[`PAU_ST_BAD_TOPO]    = bad_topo_q;
		status_word[`PAU_ST_OBJ_PENDING] = obj_valid_q;
		status_word[`PAU_ST_MID_PRIM]    = mid_prim_q;
	end

	wire [31:0] read_mux = sel_cfg ? {26'h0, cfg_q} : (sel_status ? status_word
		: (sel_count ? {16'h0000, obj_count_q} : 32'h00000000));

	// the output slot holds one object; input waits while it is occupied
	wire obj_valid_d = emit | (obj_valid_q & ~obj_ready);

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			obj_valid_q <= 1'b0;
			in_ready_q  <= 1'b1;
		end else begin
			obj_valid_q <= obj_valid_d;
			in_ready_q  <= ~obj_valid_d;
		end
	end

	// sequencing through the topology
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pos_q      <= 2'h0;
			flip_q     <= 1'b0;
			resume_q   <= 1'b0;
			mid_prim_q <= 1'b0;
		end else if (take) begin
			pos_q      <= pos_next;
			mid_prim_q <= ~vtx_end;
			flip_q     <= emit ? ~flip_cur : flip_cur;
			resume_q   <= emit ? 1'b1 : resume_c; // later strip lines continue
		end
	end

	// object slot; loaded only when the slot is free
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			shape_q    <= `PAU_SHAPE_POINT;
			nv_q       <= `PAU_NV_POINT;
			v0_q       <= '0;
			v1_q       <= '0;
			v2_q       <= '0;
			flip_out_q <= 1'b0;
			rear_q     <= 1'b0;
			pv_q       <= `PAU_PV_FIRST;
			area_q     <= 1'b0;
			dash_q     <= 1'b0;
			layer_q    <= '0;
			sel_q      <= '0;
			size_q     <= '0;
		end else if (emit) begin
			shape_q    <= shape_d;
			nv_q       <= need_nv;
			v0_q       <= v0_d;
			v1_q       <= v1_d;
			v2_q       <= v2_d;
			flip_out_q <= flip_d;
			rear_q     <= rear_d;
			pv_q       <= pv_d;
			area_q     <= area_d;
			dash_q     <= dash_d;
			layer_q    <= rec_layer(lead_rec);
			sel_q      <= rec_sel(lead_rec);
			size_q     <= is_point ? rec_size(cur_rec) : '0;
		end
	end

	// registers
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cfg_q       <= `PAU_CFG_RESET;
			bad_topo_q  <= 1'b0;
			obj_count_q <= 16'h0000;
			rdata_q     <= 32'h00000000;
		end else begin
			if (reg_write & sel_cfg) begin
				cfg_q <= reg_wdata[5:0];
			end
			// a new bad code in the clearing cycle keeps the flag set
			bad_topo_q  <= (take & ~topo_ok) | (bad_topo_q & ~clr_bad);
			obj_count_q <= (reg_write & sel_count) ? 16'h0000 : obj_count_q + {15'h0, emit};
			rdata_q     <= reg_read ? read_mux : 32'h00000000;
		end
	end

	assign reg_rdata           = rdata_q;
	assign vtx_ready           = in_ready_q;
	assign obj_valid           = obj_valid_q;
	assign shape_class         = shape_q;
	assign shape_vertex_count  = nv_q;
	assign obj_v0              = v0_q;
	assign obj_v1              = v1_q;
	assign obj_v2              = v2_q;
	assign winding_flip        = flip_out_q;
	assign rear_face_flag      = rear_q;
	assign flat_shade_source   = pv_q;
	assign area_pattern_on     = area_q;
	assign dash_pattern_resume = dash_q;
	assign obj_layer           = layer_q;
	assign obj_selector        = sel_q;
	assign obj_dot_extent      = size_q;
endmodule : pau_primitive_assembly
`default_nettype wire

// ---- verification/pau_primitive_assembly_asserts.sv ----
// port-level checks of the primitive assembly unit
`timescale 1ns/1ns
`default_nettype none
`include "pau_map.svh"
module pau_primitive_assembly_asserts #(
	parameter int DATA_W  = 32,
	parameter int LAYER_W = 11,
	parameter int SEL_W   = 4,
	parameter int SIZE_W  = 11
) (
	// clock and reset
	input wire logic                   mclk,
	input wire logic                   reset,
	// vertex stream
	input wire logic                   vtx_valid,
	input wire logic                   vtx_ready,
	input wire logic [`PAU_TOPO_W-1:0] topology_kind,
	input wire logic [LAYER_W-1:0]     layer_slot_index,
	input wire logic [SEL_W-1:0]       transform_selector,
	input wire logic [SIZE_W-1:0]      dot_extent,
	// object stream
	input wire logic                   obj_valid,
	input wire logic                   obj_ready,
	input wire logic [1:0]             shape_class,
	input wire logic [1:0]             shape_vertex_count,
	input wire logic [DATA_W-1:0]      obj_v0,
	input wire logic [DATA_W-1:0]      obj_v1,
	input wire logic [DATA_W-1:0]      obj_v2,
	input wire logic                   winding_flip,
	input wire logic                   rear_face_flag,
	input wire logic [1:0]             flat_shade_source,
	input wire logic [LAYER_W-1:0]     obj_layer,
	input wire logic [SEL_W-1:0]       obj_selector,
	input wire logic [SIZE_W-1:0]      obj_dot_extent
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// a point vertex always completes an object, so its attributes show up one cycle later
	wire logic pt_take = vtx_valid && vtx_ready &&
		(topology_kind == `PAU_TOPO_POINT_LIST || topology_kind == `PAU_TOPO_POINT_LIST_BF);

	AST_OBJ_HOLD: assert property (obj_valid && !obj_ready |=> obj_valid && $stable(obj_v0) && $stable(obj_selector))
		else $error("object changed while stalled");
	AST_STALL_INPUT: assert property (obj_valid |-> !vtx_ready)
		else $error("vertex accepted while an object waits");
	AST_VTX_COUNT: assert property (obj_valid |-> shape_vertex_count == (shape_class == 2'h0 ? 2'h1 : shape_class == 2'h1 ? 2'h2 : 2'h3))
		else $error("vertex count does not fit shape");
	AST_DOT_ONLY_POINT: assert property (obj_valid && shape_class != 2'h0 |-> obj_dot_extent == '0)
		else $error("dot extent on a non-point");
	AST_REAR_POINT_LINE: assert property (obj_valid && shape_class[1] |-> !rear_face_flag)
		else $error("rear face flag on an area shape");
	AST_WIND_TRI: assert property (obj_valid && shape_class != 2'h2 |-> !winding_flip)
		else $error("winding flip on a non-triangle");
	AST_POINT_ATTR: assert property (pt_take |=> obj_valid && obj_selector == $past(transform_selector)
		&& obj_layer == $past(layer_slot_index) && obj_dot_extent == $past(dot_extent))
		else $error("point object attributes wrong");
	AST_POINT_SRC: assert property (obj_valid && shape_class == 2'h0 |-> flat_shade_source == 2'h0 && obj_v1 == '0)
		else $error("point source or spare vertex wrong");
endmodule : pau_primitive_assembly_asserts

bind pau_primitive_assembly pau_primitive_assembly_asserts #(.DATA_W(DATA_W), .LAYER_W(LAYER_W), .SEL_W(SEL_W),
	.SIZE_W(SIZE_W)) u_asserts (.mclk(mclk), .reset(reset), .vtx_valid(vtx_valid), .vtx_ready(vtx_ready),
	.topology_kind(topology_kind), .layer_slot_index(layer_slot_index), .transform_selector(transform_selector),
	.dot_extent(dot_extent), .obj_valid(obj_valid), .obj_ready(obj_ready), .shape_class(shape_class),
	.shape_vertex_count(shape_vertex_count), .obj_v0(obj_v0), .obj_v1(obj_v1), .obj_v2(obj_v2),
	.winding_flip(winding_flip), .rear_face_flag(rear_face_flag), .flat_shade_source(flat_shade_source),
	.obj_layer(obj_layer), .obj_selector(obj_selector), .obj_dot_extent(obj_dot_extent));
`default_nettype wire

// ---- verification/pau_sink_model.sv ----
// downstream transform stage model: takes objects at once or with random stalls
`timescale 1ns/1ns
`default_nettype none
module pau_sink_model (
	// clock and reset
	input  wire logic mclk,
	input  wire logic reset,
	// stall control
	input  wire logic slow,
	// handshake
	output logic      obj_ready
);
	// slow mode takes about one cycle in three so held objects back up the vertex stream
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			obj_ready <= 1'b0;
		end else begin
			obj_ready <= !slow || $urandom_range(2) == 0;
		end
	end
endmodule : pau_sink_model
`default_nettype wire

// ---- verification/pau_primitive_assembly_tb.sv ----
// self-checking bench of the primitive assembly unit
`timescale 1ns/1ns
`default_nettype none
`include "pau_map.svh"
module pau_primitive_assembly_tb;
	logic         mclk, reset, reg_write, reg_read, vtx_valid, vtx_ready, vtx_start, vtx_end, obj_valid, obj_ready;
	logic         winding_flip, rear_face_flag, area_pattern_on, dash_pattern_resume, slow;
	logic [7:0]   reg_addr;
	logic [31:0]  reg_wdata, reg_rdata, vtx_data, obj_v0, obj_v1, obj_v2;
	logic [4:0]   topology_kind;
	logic [10:0]  layer_slot_index, dot_extent, obj_layer, obj_dot_extent;
	logic [3:0]   transform_selector, obj_selector;
	logic [1:0]   shape_class, shape_vertex_count, flat_shade_source;
	logic [5:0]   cfg;
	logic [31:0]  vd [64];
	logic [25:0]  va [64];
	logic [131:0] expq [$];
	logic [131:0] e, m;
	int           err_total, compares, n_obj, n_vtx;

	pau_primitive_assembly dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .vtx_valid(vtx_valid),
		.vtx_ready(vtx_ready), .topology_kind(topology_kind), .vtx_start(vtx_start), .vtx_end(vtx_end),
		.vtx_data(vtx_data), .layer_slot_index(layer_slot_index), .transform_selector(transform_selector),
		.dot_extent(dot_extent), .obj_valid(obj_valid), .obj_ready(obj_ready), .shape_class(shape_class),
		.shape_vertex_count(shape_vertex_count), .obj_v0(obj_v0), .obj_v1(obj_v1), .obj_v2(obj_v2),
		.winding_flip(winding_flip), .rear_face_flag(rear_face_flag), .flat_shade_source(flat_shade_source),
		.area_pattern_on(area_pattern_on), .dash_pattern_resume(dash_pattern_resume), .obj_layer(obj_layer),
		.obj_selector(obj_selector), .obj_dot_extent(obj_dot_extent));
	pau_sink_model sink (.mclk(mclk), .reset(reset), .slow(slow), .obj_ready(obj_ready));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic check(input string nm, input logic [131:0] seen, input logic [131:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic end_sim;
		if (err_total == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
		@(posedge mclk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		@(posedge mclk);
		check("register", {100'h0, reg_rdata & msk}, {100'h0, exp});
	endtask : rd

	// expected object, if any, once vertex i of a topology has been taken
	task automatic expect_obj(input logic [4:0] tk, input int i);
		int a;
		logic pt, ln, ls, fn, ts, go, wf, rf, ap, dr;
		logic [1:0] sh, nv, pv;
		logic [31:0] e1, e2;
		pt = tk <= `PAU_TOPO_POINT_LIST_BF;
		ln = tk inside {[`PAU_TOPO_LINE_LIST:`PAU_TOPO_LINE_STRIP_CBF]};
		ls = tk inside {[`PAU_TOPO_LINE_STRIP:`PAU_TOPO_LINE_STRIP_CBF]};
		ts = tk inside {`PAU_TOPO_TRI_STRIP, `PAU_TOPO_TRI_STRIP_REV};
		fn = tk inside {[`PAU_TOPO_TRI_FAN:`PAU_TOPO_POLYGON]};
		go = pt || (tk == `PAU_TOPO_LINE_LIST && i % 2 == 1) || (ls && i > 0) || ((ts || fn) && i > 1)
			|| (tk inside {`PAU_TOPO_TRI_LIST, `PAU_TOPO_RECT_LIST} && i % 3 == 2);
		a = pt ? i : ln ? i - 1 : fn ? 0 : i - 2;
		sh = pt ? 2'h0 : ln ? 2'h1 : tk == `PAU_TOPO_RECT_LIST ? 2'h3 : 2'h2;
		nv = pt ? 2'h1 : ln ? 2'h2 : 2'h3;
		pv = pt || tk == `PAU_TOPO_POLYGON ? 2'h0 : ln ? cfg[1:0] : fn ? cfg[5:4] : cfg[3:2];
		wf = ts && ((tk == `PAU_TOPO_TRI_STRIP_REV) ^ a[0]);
		rf = tk inside {`PAU_TOPO_POINT_LIST_BF, `PAU_TOPO_LINE_STRIP_BF, `PAU_TOPO_LINE_STRIP_CBF};
		ap = tk != `PAU_TOPO_TRI_FAN_NP;
		dr = ls && (i > 1 || tk inside {`PAU_TOPO_LINE_STRIP_CT, `PAU_TOPO_LINE_STRIP_CBF});
		if (go) begin
			e1 = nv == 2'h1 ? 32'h0 : vd[nv == 2'h3 ? i - 1 : i];
			e2 = nv == 2'h3 ? vd[i] : 32'h0;
			expq.push_back({sh, nv, vd[a], e1, e2, wf, rf, ap, dr, pv, va[a][25:11], pt ? va[a][10:0] : 11'h0});
		end
	endtask : expect_obj

	task automatic put(input logic [4:0] tk, input int i, input logic last);
		int n;
		vd[i] = $urandom;
		va[i] = 26'($urandom);
		vtx_valid <= 1'b1;
		topology_kind <= tk;
		vtx_start <= i == 0;
		vtx_end <= last;
		vtx_data <= vd[i];
		{layer_slot_index, transform_selector, dot_extent} <= va[i];
		for (n = 0; n < 64; n++) begin
			@(posedge mclk);
			if (vtx_ready === 1'b1) break;
		end
		if (n == 64) begin
			err_total++;
			end_sim();
		end
		expect_obj(tk, i);
	endtask : put

	// counts kept legal per topology, the smallest ones in the first pass
	function automatic int vcount(input logic [4:0] tk, input int p);
		int r;
		r = p > 0 ? $urandom_range(3) : 0;
		if (tk == `PAU_TOPO_LINE_LIST) return 2 * r + 2;
		if (tk == `PAU_TOPO_TRI_LIST || tk == `PAU_TOPO_RECT_LIST) return 3 * r + 3;
		if (tk <= `PAU_TOPO_POINT_LIST_BF) return r + 1;
		if (tk <= `PAU_TOPO_LINE_STRIP_CBF) return r + 2;
		return r + 3;
	endfunction : vcount

	always @(posedge mclk) begin
		if (obj_valid === 1'b1 && obj_ready === 1'b1) begin
			e = expq.size() > 0 ? expq.pop_front() : '1;
			m = '1;
			m[29] = e[131:130] == 2'h2;
			m[28] = e[131:130] == 2'h1;
			check("object", {shape_class, shape_vertex_count, obj_v0, obj_v1, obj_v2, winding_flip, rear_face_flag,
				area_pattern_on, dash_pattern_resume, flat_shade_source, obj_layer, obj_selector, obj_dot_extent} & m, e & m);
			n_obj++;
		end
	end

	initial begin
		void'($urandom(32'h4f168439));
		{reset, reg_write, reg_read, vtx_valid, vtx_start, vtx_end, slow} = 7'h40;
		{reg_addr, reg_wdata, topology_kind, vtx_data, layer_slot_index, transform_selector, dot_extent} = '0;
		cfg = 6'h00;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		rd(`PAU_REG_CFG, 32'hFFFFFFFF, 32'h0);
		rd(8'h0C, 32'hFFFFFFFF, 32'h0);
		for (int p = 0; p < 2; p++) begin
			slow <= p[0];
			// odd codes from 3 up follow the previous topology with no gap
			for (int t = 1; t < 15; t++) begin
				n_vtx = vcount(5'(t), p);
				for (int i = 0; i < n_vtx; i++) begin
					put(5'(t), i, i == n_vtx - 1);
				end
				if (t % 2 == 1 || t == 14) begin
					vtx_valid <= 1'b0;
					cfg = 6'($urandom);
					wr(`PAU_REG_CFG, {26'h0, cfg});
					rd(`PAU_REG_CFG, 32'h3F, {26'h0, cfg});
				end
			end
		end
		// a point loaded one edge before the read is still pending when status is sampled
		put(`PAU_TOPO_POINT_LIST, 0, 1'b1);
		vtx_valid <= 1'b0;
		rd(`PAU_REG_STATUS, 32'h2, 32'h2);
		put(5'h1F, 0, 1'b0);
		vtx_valid <= 1'b0;
		rd(`PAU_REG_STATUS, 32'h5, 32'h5);
		put(5'h1F, 1, 1'b1);
		vtx_valid <= 1'b0;
		rd(`PAU_REG_STATUS, 32'h1, 32'h1);
		wr(`PAU_REG_STATUS, 32'h1);
		rd(`PAU_REG_STATUS, 32'h1, 32'h0);
		for (int k = 0; k < 300 && expq.size() > 0; k++) @(posedge mclk);
		check("objects left", 132'(expq.size()), 132'h0);
		rd(`PAU_REG_STATUS, 32'h7, 32'h0);
		rd(`PAU_REG_OBJ_COUNT, 32'hFFFF, 32'(n_obj));
		wr(`PAU_REG_OBJ_COUNT, 32'h0);
		rd(`PAU_REG_OBJ_COUNT, 32'hFFFF, 32'h0);
		end_sim();
	end
endmodule : pau_primitive_assembly_tb
`default_nettype wire
